// ==== logic/dsc_pkg.sv ====
package dsc_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] DSC_OFF_FIRST_SRC = 8'h00;
  localparam logic [7:0] DSC_OFF_SECOND_SRC = 8'h04;
  localparam logic [7:0] DSC_OFF_INPUT_FUNC = 8'h08;
  localparam logic [7:0] DSC_OFF_SUPPLY = 8'h0C;
  localparam logic [7:0] DSC_OFF_STATUS = 8'h10;
  localparam logic [7:0] DSC_OFF_TERMINALS = 8'h14;
  localparam logic [7:0] DSC_OFF_TRIP = 8'h18;
  localparam logic [7:0] DSC_OFF_VARIANT = 8'h1C;

  // Field layout of the source, function and supply registers; input counts
  localparam int DSC_CMD_LSB = 0;
  localparam int DSC_CMD_W = 2;
  localparam int DSC_FRQ_LSB = 8;
  localparam int DSC_FRQ_W = 4;
  localparam int DSC_FUNC_W = 5;
  localparam int DSC_VOLT_W = 8;
  localparam int DSC_INPUTS_MAX = 5;
  localparam int DSC_INPUTS_STD = 3;
  localparam int DSC_FUNC_PER_WORD = 4;
  localparam int DSC_FUNC_HI_LSB = 16;

  // Command source codes
  localparam logic [1:0] DSC_CMD_KEYPAD = 2'h0;
  localparam logic [1:0] DSC_CMD_TERM1 = 2'h1;
  localparam logic [1:0] DSC_CMD_TERM2 = 2'h2;
  localparam logic [1:0] DSC_CMD_RS485 = 2'h3;

  // Frequency source codes
  localparam logic [3:0] DSC_FRQ_KEYPAD1 = 4'h0;
  localparam logic [3:0] DSC_FRQ_KEYPAD2 = 4'h1;
  localparam logic [3:0] DSC_FRQ_POT = 4'h2;
  localparam logic [3:0] DSC_FRQ_VIN = 4'h3;
  localparam logic [3:0] DSC_FRQ_I2I = 4'h4;
  localparam logic [3:0] DSC_FRQ_I2V = 4'h5;
  localparam logic [3:0] DSC_FRQ_POT_I2I = 4'h6;
  localparam logic [3:0] DSC_FRQ_POT_I2V = 4'h7;
  localparam logic [3:0] DSC_FRQ_POT_VIN = 4'h8;
  localparam logic [3:0] DSC_FRQ_RS485 = 4'h9;
  localparam logic [3:0] DSC_FRQ_UPDOWN = 4'hA;
  localparam logic [3:0] DSC_FRQ_MAX = 4'hA;

  // Multi-function input codes
  localparam logic [4:0] DSC_FUNC_SECOND_SRC = 5'h16;
  localparam logic [4:0] DSC_FUNC_MAX = 5'h1B;

  // Reset values and supply voltage limits
  localparam logic [1:0] DSC_RST_CMD = 2'h1;
  localparam logic [3:0] DSC_RST_FRQ = 4'h0;
  localparam logic [4:0] DSC_RST_FUNC = 5'h00;
  localparam logic [7:0] DSC_VOLT_MIN = 8'hAA;
  localparam logic [7:0] DSC_VOLT_MAX = 8'hF0;
  localparam logic [7:0] DSC_VOLT_RST = 8'hDC;
endpackage : dsc_pkg

// ==== logic/dsc_pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// Three-stage synchroniser with second/third stage agreement filter
module dsc_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,               // Control clock
  input wire logic rst_i,               // Synchronous reset
  input wire logic [WIDTH-1:0] pin_i,   // Asynchronous pins
  output logic [WIDTH-1:0] level_o      // Filtered levels
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;

  // Elaboration check on the width
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least one");
  end

  // Shift chain; first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a change once stages two and three agree
  genvar g;
  for (g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        lvl_q[g] <= 1'b0;
      end else if (s2_q[g] == s3_q[g]) begin
        lvl_q[g] <= s3_q[g];
      end
    end
  end

  assign level_o = lvl_q;
endmodule : dsc_pin_sync
`default_nettype wire

// ==== logic/dsc_trip_level.sv ====
`timescale 1ns/100ps
`default_nettype none
// Low-voltage trip threshold derived from the supply setting
module dsc_trip_level
  import dsc_pkg::*;
#(
  parameter int TRIP_PCT = 70
) (
  input wire logic clk_i,               // Control clock
  input wire logic rst_i,               // Synchronous reset
  input wire logic [7:0] supply_i,      // Supply voltage setting
  output logic [7:0] trip_o             // Trip level in volts
);
  // Elaboration check on the percentage
  if (TRIP_PCT < 1 || TRIP_PCT > 100) begin : g_bad_pct
    $error("TRIP_PCT out of range");
  end

  logic [15:0] prod;
  assign prod = 16'(supply_i) * 16'(TRIP_PCT);

  // Threshold follows the setting, one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_o <= 8'(16'(DSC_VOLT_RST) * 16'(TRIP_PCT) / 16'd100);
    end else begin
      trip_o <= 8'(prod / 16'd100);
    end
  end
endmodule : dsc_trip_level
`default_nettype wire

// ==== logic/dsc_command_select.sv ====
`timescale 1ns/100ps
`default_nettype none
module dsc_command_select
  import dsc_pkg::*;
#(
  parameter bit ADVANCED_IO = 1'b1,
  parameter int NUM_INPUTS = 5
) (
  input wire logic clk_i,               // Control clock 10 MHz
  input wire logic rst_i,               // Synchronous reset
  input wire logic cyc_i,               // Wishbone cycle
  input wire logic stb_i,               // Wishbone strobe
  input wire logic we_i,                // Wishbone write
  input wire logic [7:0] adr_i,         // Wishbone byte address
  input wire logic [3:0] sel_i,         // Wishbone byte selects
  input wire logic [31:0] dat_i,        // Wishbone write data
  output logic [31:0] dat_o,            // Wishbone read data
  output logic ack_o,                   // Wishbone acknowledge
  output logic err_o,                   // Wishbone error
  input wire logic [4:0] mf_pin_i,      // Multi-function input pins
  input wire logic forward_run_input_i, // Forward terminal pin
  input wire logic reverse_run_input_i, // Reverse terminal pin
  input wire logic keypad_run_i,        // Keypad run key, same clock
  input wire logic keypad_stop_i,       // Keypad stop key, same clock
  input wire logic rs485_run_i,         // RS-485 run request
  input wire logic rs485_reverse_i,     // RS-485 reverse request
  output logic run_o,                   // Run command to drive
  output logic reverse_o,               // Direction, high for reverse
  output logic decel_stop_o,            // Pulse: decelerate to stop
  output logic second_mode_o,           // Second mode in force
  output logic [1:0] cmd_src_o,         // Active command source code
  output logic [3:0] freq_src_o,        // Active frequency source code
  output logic [7:0] trip_level_o       // Low-voltage trip level
);
  // Elaboration checks on the parameters
  if (NUM_INPUTS < 1 || NUM_INPUTS > DSC_INPUTS_MAX) begin : g_bad_num
    $error("NUM_INPUTS out of range");
  end
  if (!ADVANCED_IO && NUM_INPUTS > DSC_INPUTS_STD) begin : g_bad_var
    $error("standard variant has three inputs");
  end

  logic [1:0] first_cmd_q;
  logic [3:0] first_frq_q;
  logic [1:0] second_command_source_q;
  logic [3:0] second_freq_ref_source_q;
  logic [4:0] func_q [NUM_INPUTS];
  logic [DSC_FUNC_W-1:0] func_hi;
  logic [7:0] supply_voltage_setting_q;
  logic keypad_run_q;
  logic [NUM_INPUTS-1:0] mf_lvl;
  logic [1:0] term_lvl;
  logic [NUM_INPUTS-1:0] sel_hit;
  logic selector;
  logic second_q;
  logic run_d;
  logic rev_d;
  logic run_q;
  logic ack_q;
  logic err_q;
  logic [31:0] rdata_q;
  logic req;
  logic wr;
  logic mapped;

  // Pin synchronisers for the input terminals
  dsc_pin_sync #(
    .WIDTH(NUM_INPUTS)
  ) u_mf_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(mf_pin_i[NUM_INPUTS-1:0]),
    .level_o(mf_lvl)
  );

  dsc_pin_sync #(
    .WIDTH(2)
  ) u_term_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({reverse_run_input_i, forward_run_input_i}),
    .level_o(term_lvl)
  );

  // Trip threshold from the supply setting
  dsc_trip_level u_trip (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .supply_i(supply_voltage_setting_q),
    .trip_o(trip_level_o)
  );

  // Bus request decode
  // A request is refused while its answer is out, so it is taken once
  assign req = cyc_i && stb_i && !ack_q && !err_q;
  assign wr = req && we_i && sel_i[0];
  always_comb begin
    mapped = 1'b0;
    if (adr_i[1:0] == 2'h0) begin
      case (adr_i)
        DSC_OFF_FIRST_SRC, DSC_OFF_SECOND_SRC, DSC_OFF_INPUT_FUNC,
        DSC_OFF_SUPPLY, DSC_OFF_STATUS, DSC_OFF_TERMINALS,
        DSC_OFF_TRIP, DSC_OFF_VARIANT: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // Source code legality per variant
  function automatic logic cmd_ok(input logic [1:0] c);
    cmd_ok = ADVANCED_IO || c != DSC_CMD_RS485;
  endfunction : cmd_ok

  function automatic logic frq_ok(input logic [3:0] f);
    logic adv_only;
    adv_only = f == DSC_FRQ_I2I || f == DSC_FRQ_I2V ||
               f == DSC_FRQ_POT_I2I || f == DSC_FRQ_POT_I2V ||
               f == DSC_FRQ_RS485;
    frq_ok = f <= DSC_FRQ_MAX && (ADVANCED_IO || !adv_only);
  endfunction : frq_ok

  // First and second source settings; illegal codes ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_cmd_q <= DSC_RST_CMD;
      first_frq_q <= DSC_RST_FRQ;
      second_command_source_q <= DSC_RST_CMD;
      second_freq_ref_source_q <= DSC_RST_FRQ;
    end else if (wr && sel_i[1]) begin
      if (adr_i == DSC_OFF_FIRST_SRC) begin
        if (cmd_ok(dat_i[DSC_CMD_LSB +: DSC_CMD_W])) begin
          first_cmd_q <= dat_i[DSC_CMD_LSB +: DSC_CMD_W];
        end
        if (frq_ok(dat_i[DSC_FRQ_LSB +: DSC_FRQ_W])) begin
          first_frq_q <= dat_i[DSC_FRQ_LSB +: DSC_FRQ_W];
        end
      end
      if (adr_i == DSC_OFF_SECOND_SRC) begin
        if (cmd_ok(dat_i[DSC_CMD_LSB +: DSC_CMD_W])) begin
          second_command_source_q <= dat_i[DSC_CMD_LSB +: DSC_CMD_W];
        end
        if (frq_ok(dat_i[DSC_FRQ_LSB +: DSC_FRQ_W])) begin
          second_freq_ref_source_q <= dat_i[DSC_FRQ_LSB +: DSC_FRQ_W];
        end
      end
    end
  end

  // Multi-function input function codes, one byte lane each; the
  // fifth input has its own lane in the supply word, clear of the volts
  genvar g;
  for (g = 0; g < NUM_INPUTS; g++) begin : g_func
    localparam bit LOW_WORD = g < DSC_FUNC_PER_WORD;
    localparam logic [7:0] F_ADR = LOW_WORD ? DSC_OFF_INPUT_FUNC
                                            : DSC_OFF_SUPPLY;
    localparam int F_LSB = LOW_WORD ? 8 * g : DSC_FUNC_HI_LSB;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        func_q[g] <= DSC_RST_FUNC;
      end else if (req && we_i && sel_i[F_LSB / 8] && adr_i == F_ADR) begin
        if (dat_i[F_LSB +: DSC_FUNC_W] <= DSC_FUNC_MAX) begin
          func_q[g] <= dat_i[F_LSB +: DSC_FUNC_W];
        end
      end
    end
    assign sel_hit[g] = func_q[g] == DSC_FUNC_SECOND_SRC && mf_lvl[g];
  end

  // Fifth input code for readback; zero where that input is absent
  if (NUM_INPUTS > DSC_FUNC_PER_WORD) begin : g_hi
    assign func_hi = func_q[DSC_FUNC_PER_WORD];
  end else begin : g_no_hi
    assign func_hi = '0;
  end

  assign selector = |sel_hit;

  // Supply voltage setting; an out-of-range value is dropped and the
  // last good setting, and with it the trip level, stays in force
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_voltage_setting_q <= DSC_VOLT_RST;
    end else if (wr && adr_i == DSC_OFF_SUPPLY) begin
      if (dat_i[7:0] >= DSC_VOLT_MIN && dat_i[7:0] <= DSC_VOLT_MAX) begin
        supply_voltage_setting_q <= dat_i[7:0];
      end
    end
  end

  // Registered mode flag switches both sources at once
  // It is the only path from the pins to the source mux
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      second_q <= 1'b0;
    end else begin
      second_q <= selector;
    end
  end

  // Both codes follow one mode flag, so they never straddle a switch
  assign cmd_src_o = second_q ? second_command_source_q
                              : first_cmd_q;
  assign freq_src_o = second_q ? second_freq_ref_source_q
                               : first_frq_q;
  assign second_mode_o = second_q;

  // Keypad run latch: run key sets, stop key clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keypad_run_q <= 1'b0;
    end else if (keypad_stop_i) begin
      keypad_run_q <= 1'b0;
    end else if (keypad_run_i) begin
      keypad_run_q <= 1'b1;
    end
  end

  // Run and direction from the active command source
  always_comb begin
    run_d = 1'b0;
    rev_d = 1'b0;
    case (cmd_src_o)
      DSC_CMD_KEYPAD: begin
        run_d = keypad_run_q;
      end
      DSC_CMD_TERM1: begin
        run_d = term_lvl[0] ^ term_lvl[1];
        rev_d = term_lvl[1] && !term_lvl[0];
      end
      DSC_CMD_TERM2: begin
        run_d = term_lvl[0];
        rev_d = term_lvl[1];
      end
      DSC_CMD_RS485: begin
        run_d = rs485_run_i;
        rev_d = rs485_reverse_i;
      end
      default: begin
        run_d = 1'b0;
      end
    endcase
  end

  // Run and direction follow the active source one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
      reverse_o <= 1'b0;
    end else begin
      run_q <= run_d;
      reverse_o <= rev_d;
    end
  end

  // Stop pulse in the cycle run drops, whatever made it drop except reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      decel_stop_o <= 1'b0;
    end else begin
      decel_stop_o <= run_q && !run_d;
    end
  end

  assign run_o = run_q;

  // Bus answer: ack one cycle after request, err on unmapped
  // Misaligned or unused addresses get err and no register moves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= req && mapped;
      err_q <= req && !mapped;
    end
  end

  assign ack_o = ack_q;
  assign err_o = err_q;

  // Read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0;
    end else if (req && !we_i) begin
      rdata_q <= 32'h0;
      case (adr_i)
        DSC_OFF_FIRST_SRC: begin
          rdata_q[DSC_CMD_LSB +: DSC_CMD_W] <= first_cmd_q;
          rdata_q[DSC_FRQ_LSB +: DSC_FRQ_W] <= first_frq_q;
        end
        DSC_OFF_SECOND_SRC: begin
          rdata_q[DSC_CMD_LSB +: DSC_CMD_W] <= second_command_source_q;
          rdata_q[DSC_FRQ_LSB +: DSC_FRQ_W] <= second_freq_ref_source_q;
        end
        DSC_OFF_INPUT_FUNC: begin
          for (int i = 0; i < NUM_INPUTS && i < DSC_FUNC_PER_WORD; i++) begin
            rdata_q[8*i +: DSC_FUNC_W] <= func_q[i];
          end
        end
        DSC_OFF_SUPPLY: begin
          rdata_q[7:0] <= supply_voltage_setting_q;
          rdata_q[DSC_FUNC_HI_LSB +: DSC_FUNC_W] <= func_hi;
        end
        DSC_OFF_STATUS: begin
          rdata_q[0] <= second_q;
          rdata_q[1] <= run_q;
          rdata_q[2] <= reverse_o;
          rdata_q[5:4] <= cmd_src_o;
          rdata_q[11:8] <= freq_src_o;
        end
        DSC_OFF_TERMINALS: begin
          rdata_q[NUM_INPUTS-1:0] <= mf_lvl;
          rdata_q[9:8] <= term_lvl;
        end
        DSC_OFF_TRIP: rdata_q[7:0] <= trip_level_o;
        DSC_OFF_VARIANT: rdata_q[0] <= ADVANCED_IO;
        default: rdata_q <= 32'h0;
      endcase
    end
  end

  assign dat_o = rdata_q;
endmodule : dsc_command_select
`default_nettype wire

// ==== tb/dsc_command_select_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
// Protocol and timing checks at the selector's ports
module dsc_command_select_asserts
  import dsc_pkg::*;
(
  input wire logic clk_i,              // Clock
  input wire logic rst_i,              // Reset
  input wire logic cyc_i,              // Bus cycle
  input wire logic stb_i,              // Bus strobe
  input wire logic we_i,               // Bus write
  input wire logic [7:0] adr_i,        // Bus address
  input wire logic [31:0] dat_o,       // Read data
  input wire logic ack_o,              // Acknowledge
  input wire logic err_o,              // Bus error
  input wire logic [4:0] mf_pin_i,     // Input pins
  input wire logic run_o,              // Run command
  input wire logic decel_stop_o,       // Stop pulse
  input wire logic second_mode_o,      // Mode flag
  input wire logic [1:0] cmd_src_o,    // Command source
  input wire logic [3:0] freq_src_o,   // Frequency source
  input wire logic [7:0] trip_level_o  // Trip level
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus answers
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_time_a: assert property (cyc_i && stb_i && !ack_o && !err_o
    |=> ack_o || err_o) else $error("bus request not answered");
  resp_excl_a: assert property (!(ack_o && err_o))
    else $error("ack and err together");
  dat_hold_a: assert property ($changed(dat_o) |-> ack_o || err_o)
    else $error("read data moved without answer");
  // Mode and source selection
  mode_pin_a: assert property (
    $rose(second_mode_o) |-> $past(mf_pin_i, 4) != 5'h00)
    else $error("second mode without input pin");
  src_cause_a: assert property (
    $changed(cmd_src_o) || $changed(freq_src_o)
    |-> $changed(second_mode_o) || ($rose(ack_o) && we_i))
    else $error("source moved without cause");
  // Stopping
  stop_pulse_a: assert property ($fell(run_o) |-> decel_stop_o)
    else $error("no stop pulse after run fell");
  decel_why_a: assert property (
    decel_stop_o |-> !run_o && $past(run_o))
    else $error("stray stop pulse");
  // Trip level follows only a supply write
  trip_cause_a: assert property (
    $changed(trip_level_o)
    |-> $past(ack_o && we_i && adr_i == DSC_OFF_SUPPLY))
    else $error("trip level moved without write");

  mode_cov: cover property ($rose(second_mode_o));
  stop_cov: cover property (decel_stop_o);
  err_cov: cover property (err_o);
endmodule : dsc_command_select_asserts
`default_nettype wire

// ==== tb/dsc_far_side.sv ====
`timescale 1ns/100ps
`default_nettype none
// Terminals, keypad and serial host driving the selector
module dsc_far_side (
  input wire logic clk_i,             // Clock
  input wire logic [4:0] pin_req_i,   // Wanted pin levels
  input wire logic [1:0] term_req_i,  // Wanted fwd, rev
  input wire logic [1:0] key_req_i,   // Run, stop keys held
  input wire logic [1:0] host_req_i,  // Host run, reverse
  output logic [4:0] mf_pin_o,        // Multi-function pins
  output logic fwd_o,                 // Forward terminal
  output logic rev_o,                 // Reverse terminal
  output logic key_run_o,             // Run key pulse
  output logic key_stop_o,            // Stop key pulse
  output logic host_run_o,            // Host run level
  output logic host_rev_o             // Host reverse level
);
  logic [1:0] key_q;
  // Everything idle at power up
  initial begin
    {mf_pin_o, fwd_o, rev_o, key_run_o, key_stop_o} = 9'h000;
    {host_run_o, host_rev_o, key_q} = 4'h0;
  end
  // Levels change after an edge; a key press gives one pulse
  always @(posedge clk_i) begin
    mf_pin_o <= pin_req_i;
    {fwd_o, rev_o} <= term_req_i;
    {host_run_o, host_rev_o} <= host_req_i;
    key_q <= key_req_i;
    key_run_o <= key_req_i[1] & ~key_q[1];
    key_stop_o <= key_req_i[0] & ~key_q[0];
  end
endmodule : dsc_far_side
`default_nettype wire

// ==== tb/dsc_command_select_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module dsc_command_select_bench;
  import dsc_pkg::*;
  localparam int TRIP_PCT = 70;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rd, dat;
  logic ack, err, erd, run, rev, dec, mode, fwd, rvs, kr, ks, hr, hv;
  logic [1:0] csrc, term_q = 2'h0, key_q = 2'h0, host_q = 2'h0;
  logic [3:0] fsrc;
  logic [7:0] trip;
  logic [4:0] mf, pin_q = 5'h00;
  logic [7:0] vt [5];
  int n_fail = 0, n_tests = 0, cyc_n = 0, n_dec = 0, d0, idx, rf, i;

  always #50 clk = ~clk;

  dsc_command_select #(.ADVANCED_IO(1'b1), .NUM_INPUTS(5)) dut_u (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat), .ack_o(ack),
    .err_o(err), .mf_pin_i(mf), .forward_run_input_i(fwd),
    .reverse_run_input_i(rvs), .keypad_run_i(kr), .keypad_stop_i(ks),
    .rs485_run_i(hr), .rs485_reverse_i(hv), .run_o(run),
    .reverse_o(rev), .decel_stop_o(dec), .second_mode_o(mode),
    .cmd_src_o(csrc), .freq_src_o(fsrc), .trip_level_o(trip));

  dsc_far_side far_u (.clk_i(clk), .pin_req_i(pin_q),
    .term_req_i(term_q), .key_req_i(key_q), .host_req_i(host_q),
    .mf_pin_o(mf), .fwd_o(fwd), .rev_o(rvs), .key_run_o(kr),
    .key_stop_o(ks), .host_run_o(hr), .host_rev_o(hv));

  task automatic wrap_up;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk

  // One classic bus cycle; data and error taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int k = 0;
    @(posedge clk);
    {cyc, stb, we, sel} <= {2'b11, w, 4'hF};
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
    rd = dat;
    erd = err;
    if (k == 20) chk(32'h0, 32'h1);
    {cyc, stb, we, sel} <= 7'h00;
  endtask : wb

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wmode(input logic v);
    int k = 0;
    while (mode !== v && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk(mode, v);
  endtask : wmode

  function automatic logic [31:0] srcw(input logic [1:0] c,
                                       input logic [3:0] f);
    return {20'h0, f, 6'h0, c};
  endfunction : srcw

  function automatic logic [31:0] trip_exp(input logic [7:0] v);
    return 32'(v) * 32'(TRIP_PCT) / 32'd100;
  endfunction : trip_exp

  // Stop pulses seen
  always @(posedge clk) if (dec === 1'b1) n_dec++;

  // Hang guard
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 4000) begin
      n_fail++;
      $display("Error %0t: timeout", $time);
      wrap_up();
    end
  end

  initial begin
    void'($urandom(96101));
    tick(3);
    rst <= 1'b0;
    tick(1);
    chk(csrc, DSC_RST_CMD);
    chk(fsrc, DSC_RST_FRQ);
    chk(trip, trip_exp(DSC_VOLT_RST));
    wb(1'b0, DSC_OFF_VARIANT, 0);
    chk(rd[0], 1'b1);
    wb(1'b1, 8'h20, 0);
    chk(erd, 1'b1);
    $display("done: reset and map");
    // Every frequency code, random command codes, then a bad code
    for (i = 0; i <= 11; i++) begin
      idx = (i == 11) ? $urandom_range(15, 11) : i;
      rf = $urandom_range(3);
      wb(1'b1, DSC_OFF_FIRST_SRC, srcw(rf, idx));
      chk(csrc, rf);
      chk(fsrc, (i == 11) ? 10 : i);
    end
    $display("done: source codes");
    vt = '{8'hAA, 8'hF0, 8'($urandom_range(240, 170)), 8'hA9, 8'hF1};
    for (i = 0; i < 5; i++) begin
      wb(1'b1, DSC_OFF_SUPPLY, vt[i]);
      tick(2);
      chk(trip, trip_exp(vt[i < 3 ? i : 2]));
      wb(1'b0, DSC_OFF_SUPPLY, 0);
      chk(rd[7:0], vt[i < 3 ? i : 2]);
    end
    $display("done: supply");
    idx = $urandom_range(3);
    rf = $urandom_range(10);
    wb(1'b1, DSC_OFF_FIRST_SRC, srcw(DSC_CMD_RS485, DSC_FRQ_KEYPAD1));
    wb(1'b1, DSC_OFF_SECOND_SRC, srcw(DSC_CMD_TERM1, rf));
    wb(1'b1, DSC_OFF_INPUT_FUNC, 32'(DSC_FUNC_SECOND_SRC) << (8 * idx));
    host_q <= 2'b10;
    term_q <= 2'b10;
    tick(6);
    chk(run, 1'b1);
    d0 = n_dec;
    pin_q <= 5'(1 << idx);
    wmode(1'b1);
    chk(csrc, DSC_CMD_TERM1);
    chk(fsrc, rf);
    tick(4);
    chk(run, 1'b1);
    chk(n_dec - d0, 0);
    host_q <= 2'b00;
    pin_q <= 5'h00;
    wmode(1'b0);
    chk(csrc, DSC_CMD_RS485);
    chk(fsrc, DSC_FRQ_KEYPAD1);
    tick(4);
    chk(run, 1'b0);
    chk(n_dec - d0, 1);
    host_q <= 2'b10;
    term_q <= 2'b00;
    tick(6);
    chk(run, 1'b1);
    pin_q <= 5'(1 << idx);
    wmode(1'b1);
    tick(4);
    chk(run, 1'b0);
    chk(n_dec - d0, 2);
    wb(1'b1, DSC_OFF_INPUT_FUNC, 32'(5'h15) << (8 * idx));
    wmode(1'b0);
    pin_q <= 5'h00;
    host_q <= 2'b00;
    // Fifth input as selector, its code in the supply word
    wb(1'b1, DSC_OFF_SUPPLY,
       {11'h0, DSC_FUNC_SECOND_SRC, 8'h00, DSC_VOLT_RST});
    wb(1'b0, DSC_OFF_SUPPLY, 0);
    chk(rd[DSC_FUNC_HI_LSB +: DSC_FUNC_W], DSC_FUNC_SECOND_SRC);
    pin_q <= 5'h10;
    wmode(1'b1);
    pin_q <= 5'h00;
    wmode(1'b0);
    $display("done: second mode");
    wb(1'b1, DSC_OFF_FIRST_SRC, srcw(DSC_CMD_TERM2, 0));
    term_q <= 2'b11;
    tick(8);
    chk({run, rev}, 2'b11);
    term_q <= 2'b10;
    tick(8);
    chk({run, rev}, 2'b10);
    wb(1'b1, DSC_OFF_FIRST_SRC, srcw(DSC_CMD_TERM1, 0));
    term_q <= 2'b01;
    tick(8);
    chk({run, rev}, 2'b11);
    term_q <= 2'b11;
    tick(8);
    chk(run, 1'b0);
    wb(1'b1, DSC_OFF_FIRST_SRC, srcw(DSC_CMD_KEYPAD, 0));
    key_q <= 2'b10;
    tick(4);
    chk(run, 1'b1);
    key_q <= 2'b01;
    tick(4);
    chk(run, 1'b0);
    $display("done: command schemes");
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    tick(1);
    chk(csrc, DSC_RST_CMD);
    chk(trip, trip_exp(DSC_VOLT_RST));
    $display("done: second reset");
    wrap_up();
  end
endmodule : dsc_command_select_bench

bind dsc_command_select dsc_command_select_asserts chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o), .mf_pin_i(mf_pin_i), .run_o(run_o),
  .decel_stop_o(decel_stop_o), .second_mode_o(second_mode_o),
  .cmd_src_o(cmd_src_o), .freq_src_o(freq_src_o),
  .trip_level_o(trip_level_o));
`default_nettype wire
